// >>> sp_pkg.sv
// constants for the serial port with baud generators
package sp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BUF_OFS = 8'h04;
  localparam logic [7:0] PWR_OFS = 8'h08;
  localparam logic [7:0] TIMER_MODE_OFS = 8'h0C;
  localparam logic [7:0] T1_OFS = 8'h10;
  localparam logic [7:0] T2CTL_OFS = 8'h14;
  localparam logic [7:0] RCAP_OFS = 8'h18;
  localparam logic [7:0] T2_OFS = 8'h1C;
  // serial_control_reg fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int MPE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int TXD_BIT = 1;
  localparam int RXD_BIT = 0;
  // power_control_reg field
  localparam int DOUBLE_BIT = 7;
  // timer_mode_reg fields (timer 1 mode and counter select in the upper nibble, run at bit 0)
  localparam int T1_CT_BIT = 6;
  localparam int T1_MODE_HI = 5;
  localparam int T1_MODE_LO = 4;
  localparam int T1_RUN_BIT = 0;
  // timer2_control_reg fields
  localparam int RX_CLK_SEL_BIT = 5;
  localparam int TX_CLK_SEL_BIT = 4;
  localparam int T2_RUN_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // timing: oscillator is the 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int MC_NS = 120;
  localparam int MC_CLOCKS = MC_NS / CLK_PERIOD_NS;
  localparam int STATE_CLOCKS = 2;
  localparam int MODE2_SLOW = 4;
  localparam logic [3:0] SAMPLE_POS = 4'h7;
  localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
  localparam logic [3:0] MC_SAMPLE = 4'h9;
  localparam logic [3:0] SCLK_LOW_FIRST = 4'h4;
  localparam logic [3:0] SCLK_LOW_LAST = 4'h9;
  // mode encodings
  typedef enum logic [1:0] {SP_SHIFT, SP_ASYNC8, SP_ASYNC9F, SP_ASYNC9V} sp_mode_type;
endpackage : sp_pkg

// >>> sp_serial_port.sv
// serial port with four modes, timer 1 and timer 2 baud sources
// Behaviour
// - mode 0: 8 bits LSB first, osc/12
// - mode 1: start, 8 data, stop into ninth
// - mode 2: 11 bits, ninth from tx_ninth_bit
// - modes 2/3: ninth stored, stop ignored
// - mode 3 equals mode 2, timer baud
// - buffer write starts transmission
// - mode 0 receives when enabled, flag clear
// - modes 1-3 receive on start bit
// - multiproc: interrupt only if ninth set
// - multiproc enable ignored in mode 0
// - mode 1 multiproc needs valid stop
// - control register holds mode, ninths, flags
// - mode 2 baud osc*2^double/64
// - timer 1 baud overflow*2^double/32
// - timer 1 modes 0-2, timer or counter
// - auto-reload baud from timer1_high_byte
// - timer 1 and 2 per direction
// - clock selects put timer 2 in baud mode
// - timer 2 rollover reloads from capture regs
// - buffer write to tx, read from rx
// - receive buffered, overrun loses a byte
module sp_serial_port #(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o,
  input wire logic t1_count_i
);
  if (ADR_W < 5 || ADR_W > 8)
  begin : g_adr_check
    $error("address width must be 5 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl;
  logic [7:0] rx_data;
  logic baud_double;
  logic [7:0] timer_mode;
  logic [7:0] tl1;
  logic [7:0] th1;
  logic [7:0] t2ctl;
  logic [15:0] rcap;
  logic [15:0] t2;
  logic [7:0] adr;
  logic wr;
  logic [1:0] mode;
  logic [3:0] mc;
  logic mc_tick;
  logic [1:0] q4;
  logic cnt_prev;
  logic t1_inc;
  logic t1_ovf;
  logic t1_half;
  logic t1_tick;
  logic t2_baud;
  logic t2_inc;
  logic t2_ovf;
  logic m2_tick;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] tx_div;
  logic [3:0] rx_div;
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic tx_pend;
  logic tx_busy;
  logic tx_bit;
  logic tx_step;
  logic tx_end;
  logic [8:0] rx_shift;
  logic [3:0] rx_cnt;
  logic rx_busy;
  logic rx0_busy;
  logic rxd_prev;
  logic rx_start;
  logic rx_sample;
  logic rx_abort;
  logic rx_last;
  logic rx0_start;
  logic rx0_last;
  logic rx_load;
  logic [7:0] next_rx_data;
  logic next_rx9;
  logic sclk_low;

  assign adr = 8'(wb_adr_i);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign mode = ctrl[sp_pkg::MODE_HI:sp_pkg::MODE_LO];

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, writes land on the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (adr)
        sp_pkg::CTRL_OFS: wb_dat_o <= {24'h00_0000, ctrl};
        sp_pkg::BUF_OFS: wb_dat_o <= {24'h00_0000, rx_data};
        sp_pkg::PWR_OFS: wb_dat_o <= {24'h00_0000, baud_double, 7'h00};
        sp_pkg::TIMER_MODE_OFS: wb_dat_o <= {24'h00_0000, timer_mode};
        sp_pkg::T1_OFS: wb_dat_o <= {16'h0000, th1, tl1};
        sp_pkg::T2CTL_OFS: wb_dat_o <= {24'h00_0000, t2ctl};
        sp_pkg::RCAP_OFS: wb_dat_o <= {16'h0000, rcap};
        sp_pkg::T2_OFS: wb_dat_o <= {16'h0000, t2};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      baud_double <= 1'b0;
      timer_mode <= sp_pkg::BYTE_RST;
      t2ctl <= sp_pkg::BYTE_RST;
      rcap <= sp_pkg::WORD_RST;
    end
    else if (wr)
    begin
      if (adr == sp_pkg::PWR_OFS && wb_sel_i[0])
        baud_double <= wb_dat_i[sp_pkg::DOUBLE_BIT];
      if (adr == sp_pkg::TIMER_MODE_OFS && wb_sel_i[0])
        timer_mode <= wb_dat_i[7:0];
      if (adr == sp_pkg::T2CTL_OFS && wb_sel_i[0])
        t2ctl <= wb_dat_i[7:0];
      if (adr == sp_pkg::RCAP_OFS && wb_sel_i[0])
        rcap[7:0] <= wb_dat_i[7:0];
      if (adr == sp_pkg::RCAP_OFS && wb_sel_i[1])
        rcap[15:8] <= wb_dat_i[15:8];
    end
  end

  // control register: hardware sets of the done flags win over software clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= sp_pkg::CTRL_RST;
    else
    begin
      if (wr && adr == sp_pkg::CTRL_OFS && wb_sel_i[0])
        ctrl <= wb_dat_i[7:0];
      if (rx_load)
        ctrl[sp_pkg::RX9_BIT] <= next_rx9;
      if (rx_load)
        ctrl[sp_pkg::RXD_BIT] <= 1'b1;
      if (tx_end)
        ctrl[sp_pkg::TXD_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle and state-time prescalers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mc <= 4'h0;
      q4 <= 2'h0;
      cnt_prev <= 1'b0;
    end
    else
    begin
      mc <= (mc == sp_pkg::MC_LAST) ? 4'h0 : mc + 4'h1;
      q4 <= q4 + 2'h1;
      cnt_prev <= t1_count_i;
    end
  end
  assign mc_tick = (mc == sp_pkg::MC_LAST);
  // mode 2: 16x tick at osc/4 or osc/2, giving osc/64 or osc/32 per bit
  assign m2_tick = baud_double ? q4[0] : (q4 == 2'(sp_pkg::MODE2_SLOW - 1));

  // timer 1: timer on machine cycles or counter on input edges, modes 0..2
  assign t1_inc = timer_mode[sp_pkg::T1_RUN_BIT] & (timer_mode[sp_pkg::T1_CT_BIT] ?
                  (cnt_prev & ~t1_count_i) : mc_tick);
  always_comb
  begin
    case (timer_mode[sp_pkg::T1_MODE_HI:sp_pkg::T1_MODE_LO])
      2'h0: t1_ovf = t1_inc & (th1 == 8'hFF) & (tl1[4:0] == 5'h1F);
      2'h1: t1_ovf = t1_inc & ({th1, tl1} == 16'hFFFF);
      2'h2: t1_ovf = t1_inc & (tl1 == 8'hFF);
      default: t1_ovf = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tl1 <= sp_pkg::BYTE_RST;
      th1 <= sp_pkg::BYTE_RST;
    end
    else if (wr && adr == sp_pkg::T1_OFS)
    begin
      if (wb_sel_i[0])
        tl1 <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        th1 <= wb_dat_i[15:8];
    end
    else if (t1_inc)
    begin
      case (timer_mode[sp_pkg::T1_MODE_HI:sp_pkg::T1_MODE_LO])
        2'h0:
        begin
          tl1[4:0] <= tl1[4:0] + 5'h01;
          if (tl1[4:0] == 5'h1F)
            th1 <= th1 + 8'h01;
        end
        2'h1: {th1, tl1} <= {th1, tl1} + 16'h0001;
        2'h2: tl1 <= t1_ovf ? th1 : tl1 + 8'h01;
        default: tl1 <= tl1;
      endcase
    end
  end

  // halve timer 1 overflows unless doubled: overflow/32 per bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      t1_half <= 1'b0;
    else if (t1_ovf)
      t1_half <= ~t1_half;
  end
  assign t1_tick = t1_ovf & (baud_double | t1_half);

  // timer 2: baud generator counts state times, reload from capture pair
  assign t2_baud = t2ctl[sp_pkg::RX_CLK_SEL_BIT] | t2ctl[sp_pkg::TX_CLK_SEL_BIT];
  assign t2_inc = t2ctl[sp_pkg::T2_RUN_BIT] & (t2_baud ? (q4[0] == 1'b1) : mc_tick);
  assign t2_ovf = t2_inc & (t2 == 16'hFFFF);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      t2 <= sp_pkg::WORD_RST;
    else if (wr && adr == sp_pkg::T2_OFS)
    begin
      if (wb_sel_i[0])
        t2[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        t2[15:8] <= wb_dat_i[15:8];
    end
    else if (t2_ovf)
      t2 <= rcap;
    else if (t2_inc)
      t2 <= t2 + 16'h0001;
  end

  // per-direction 16x ticks
  always_comb
  begin
    if (mode == sp_pkg::SP_ASYNC9F)
    begin
      tx_tick = m2_tick;
      rx_tick = m2_tick;
    end
    else
    begin
      tx_tick = t2ctl[sp_pkg::TX_CLK_SEL_BIT] ? t2_ovf : t1_tick;
      rx_tick = t2ctl[sp_pkg::RX_CLK_SEL_BIT] ? t2_ovf : t1_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter; bit times follow the divide-by-16 (the machine cycle in mode 0), not the buffer write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_div <= 4'h0;
    else if (tx_tick)
      tx_div <= tx_div + 4'h1;
  end
  assign tx_step = (mode == sp_pkg::SP_SHIFT) ? mc_tick : (tx_tick & (tx_div == 4'hF));
  assign tx_end = tx_busy & tx_step & (tx_left == 4'h0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_pend <= 1'b0;
      tx_busy <= 1'b0;
      tx_bit <= 1'b1;
    end
    else if (wr && adr == sp_pkg::BUF_OFS && wb_sel_i[0])
    begin
      tx_pend <= 1'b1;
      tx_busy <= 1'b0;
      tx_bit <= 1'b1;
      case (mode)
        sp_pkg::SP_SHIFT: tx_shift <= {3'h7, wb_dat_i[7:0]};
        sp_pkg::SP_ASYNC8: tx_shift <= {2'h3, wb_dat_i[7:0], 1'b0};
        default: tx_shift <= {1'b1, ctrl[sp_pkg::TX9_BIT], wb_dat_i[7:0], 1'b0};
      endcase
    end
    else if (tx_step && tx_pend && !rx0_busy)
    begin
      tx_pend <= 1'b0;
      tx_busy <= 1'b1;
      tx_bit <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[10:1]};
      case (mode)
        sp_pkg::SP_SHIFT: tx_left <= 4'h7;
        sp_pkg::SP_ASYNC8: tx_left <= 4'h9;
        default: tx_left <= 4'hA;
      endcase
    end
    else if (tx_step && tx_busy)
    begin
      if (tx_left == 4'h0)
      begin
        tx_busy <= 1'b0;
        tx_bit <= 1'b1;
      end
      else
      begin
        tx_left <= tx_left - 4'h1;
        tx_bit <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[10:1]};
      end
    end
  end

  // shift clock low for the middle of each machine cycle
  assign sclk_low = (mc >= sp_pkg::SCLK_LOW_FIRST) && (mc <= sp_pkg::SCLK_LOW_LAST);
  always_comb
  begin
    if (mode == sp_pkg::SP_SHIFT)
    begin
      txd_o = ~((tx_busy | rx0_busy) & sclk_low);
      rxd_o = tx_bit;
      rxd_oe_o = tx_busy;
    end
    else
    begin
      txd_o = tx_bit;
      rxd_o = 1'b1;
      rxd_oe_o = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver; rx_shift is separate from the readable byte, so one frame overlaps
  assign rx_start = (mode != sp_pkg::SP_SHIFT) & ~rx_busy & ctrl[sp_pkg::REN_BIT]
                    & rxd_prev & ~rxd_i;
  assign rx_sample = rx_busy & rx_tick & (rx_div == sp_pkg::SAMPLE_POS);
  assign rx_abort = rx_sample & (rx_cnt == 4'h0) & rxd_i;
  assign rx_last = rx_sample & (rx_cnt == ((mode == sp_pkg::SP_ASYNC8) ? 4'h9 : 4'hA));
  assign rx0_start = (mode == sp_pkg::SP_SHIFT) & ~rx0_busy & ~tx_busy & ~tx_pend
                     & ctrl[sp_pkg::REN_BIT] & ~ctrl[sp_pkg::RXD_BIT] & mc_tick;
  assign rx0_last = rx0_busy & (mc == sp_pkg::MC_SAMPLE) & (rx_cnt == 4'h7);

  always_comb
  begin
    next_rx_data = rx_shift[7:0];
    next_rx9 = rx_shift[8];
    if (mode == sp_pkg::SP_ASYNC8)
    begin
      next_rx_data = rx_shift[8:1];
      next_rx9 = rxd_i;
    end
    else if (mode == sp_pkg::SP_SHIFT)
    begin
      next_rx_data = {rxd_i, rx_shift[8:2]};
      next_rx9 = ctrl[sp_pkg::RX9_BIT];
    end
  end
  // an unread byte blocks the load, so the newer frame is the one lost
  assign rx_load = rx0_last | (rx_last & ~ctrl[sp_pkg::RXD_BIT]
                   & (~ctrl[sp_pkg::MPE_BIT] | next_rx9));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_div <= 4'h0;
      rx_cnt <= 4'h0;
      rx_busy <= 1'b0;
      rx0_busy <= 1'b0;
      rx_shift <= 9'h1FF;
      rxd_prev <= 1'b1;
    end
    else
    begin
      rxd_prev <= rxd_i;
      if (rx_start)
      begin
        rx_busy <= 1'b1;
        rx_div <= 4'h0;
        rx_cnt <= 4'h0;
        rx_shift <= 9'h1FF;
      end
      else if (rx0_start)
      begin
        rx0_busy <= 1'b1;
        rx_cnt <= 4'h0;
      end
      else if (rx0_busy && mc == sp_pkg::MC_SAMPLE)
      begin
        rx_shift <= {rxd_i, rx_shift[8:1]};
        rx_cnt <= rx_cnt + 4'h1;
        rx0_busy <= ~rx0_last;
      end
      else if (rx_busy && rx_tick)
      begin
        rx_div <= rx_div + 4'h1;
        if (rx_abort || rx_last)
          rx_busy <= 1'b0;
        if (rx_sample)
        begin
          rx_shift <= {rxd_i, rx_shift[8:1]};
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
      if (mode == sp_pkg::SP_SHIFT)
        rx_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_data <= sp_pkg::BYTE_RST;
    else if (rx_load)
      rx_data <= next_rx_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  double_reset_a: assert property (@(posedge clk_i)
    rst_i |=> !baud_double) else $error("baud double not cleared");
  tx_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr == sp_pkg::BUF_OFS && wb_sel_i[0]) |=> tx_pend) else $error("no tx pend");
  rx_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_load |=> ctrl[sp_pkg::RXD_BIT] && rx_data == $past(next_rx_data))
    else $error("rx load lost");
  mp_filter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_load && mode != sp_pkg::SP_SHIFT && ctrl[sp_pkg::MPE_BIT]) |-> next_rx9)
    else $error("filtered frame loaded");
  t2_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (t2_ovf && !wr) |=> t2 == $past(rcap)) else $error("no t2 reload");
  tx_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_end |=> ctrl[sp_pkg::TXD_BIT] && !tx_busy) else $error("tx end not flagged");
  shift_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rxd_oe_o |-> mode == sp_pkg::SP_SHIFT && tx_busy) else $error("data pin driven");
  async_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode != sp_pkg::SP_SHIFT && !tx_busy) |-> txd_o) else $error("line not idle high");
  rx_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rx_busy) |-> $past(ctrl[sp_pkg::REN_BIT])) else $error("rx without enable");
endmodule : sp_serial_port

// >>> sp_remote.sv
// far-end serial peer: async frames and mode 0 shift partner
module sp_remote (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic pin_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles high, as a pull-up would hold it
  initial line_o = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic await(input logic v, inout int k);
    while (txd_i !== v && k < 5000)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask : await
  //////////////////////////////////////////////////////////////////////////////
  // frame bits lsb first, start bit in bit 0
  task automatic send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++)
    begin
      line_o <= f[i];
      repeat (bt) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
  //////////////////////////////////////////////////////////////////////////////
  // mid-bit sampling tolerates a tick of phase error
  task automatic recv(input int n, input int bt, output logic [10:0] f);
    int k;
    k = 0;
    f = '1;
    await(1'b0, k);
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd_i;
      repeat (bt) @(posedge clk_i);
    end
  endtask : recv
  //////////////////////////////////////////////////////////////////////////////
  // data set on the clock fall, taken on the rise
  task automatic shift(input logic [7:0] din, output logic [7:0] dout, output int per);
    int k;
    int t;
    k = 0;
    t = 0;
    for (int i = 0; i < 8; i++)
    begin
      await(1'b0, k);
      line_o <= din[i];
      await(1'b1, k);
      dout[i] = pin_i;
      if (i == 6)
        t = k;
    end
    per = k - t;
    line_o <= 1'b1;
  endtask : shift
endmodule : sp_remote

// >>> tb_top.sv
// testbench for the serial port: bus cycles and line traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, rxd_o, rxd_oe, txd, line, pin, t1c;
  logic [7:0] wb_adr;
  logic [31:0] wb_wdat, wb_rdat;
  logic [7:0] b;
  int per;
  int mismatches = 0;
  int n_tests = 0;
  // shared data pin: the device wins while it drives
  assign pin = rxd_oe ? rxd_o : line;
  sp_serial_port DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rxd_i(pin), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe), .txd_o(txd), .t1_count_i(t1c)
  );
  sp_remote far (.clk_i(clk_i), .txd_i(txd), .pin_i(pin), .line_o(line));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // no fixed answer time assumed: wait for ack, bounded
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (k >= 50)
      mismatches++;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(nm, q, e);
  endtask : rdchk
  //////////////////////////////////////////////////////////////////////////////
  task automatic txf(input logic [7:0] d, input int n, input int bt, input logic [10:0] e);
    logic [10:0] f;
    wr(sp_pkg::BUF_OFS, {24'h0, d});
    far.recv(n, bt, f);
    check("frame", {21'h0, f}, {21'h0, e});
  endtask : txf
  task automatic rxf(input logic [10:0] f, input int n, input int bt, input logic [7:0] ec,
                     input logic [7:0] eb);
    far.send(f, n, bt);
    repeat (bt) @(posedge clk_i);
    rdchk(sp_pkg::CTRL_OFS, {24'h0, ec}, "rx ctrl");
    rdchk(sp_pkg::BUF_OFS, {24'h0, eb}, "rx buf");
  endtask : rxf
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
  initial
  begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    t1c = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(sp_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rdchk(sp_pkg::PWR_OFS, 32'h0, "double reset");
    rdchk(8'h20, 32'h0, "unmapped");
    // mode 2 at osc/64, then osc/32
    wr(sp_pkg::CTRL_OFS, 32'h98);
    txf(8'hA5, 11, 64, {2'b11, 8'hA5, 1'b0});
    rdchk(sp_pkg::CTRL_OFS, 32'h9A, "tx done");
    wr(sp_pkg::PWR_OFS, 32'h80);
    wr(sp_pkg::CTRL_OFS, 32'h90);
    txf(8'h3C, 11, 32, {2'b10, 8'h3C, 1'b0});
    wr(sp_pkg::CTRL_OFS, 32'h90);
    // bad stop bit must not matter in mode 2
    rxf({2'b01, 8'h5A, 1'b0}, 11, 32, 8'h95, 8'h5A);
    // flag still set: newer byte is lost
    rxf({2'b10, 8'h11, 1'b0}, 11, 32, 8'h95, 8'h5A);
    wr(sp_pkg::CTRL_OFS, 32'hB0);
    rxf({2'b10, 8'h22, 1'b0}, 11, 32, 8'hB0, 8'h5A);
    rxf({2'b11, 8'h33, 1'b0}, 11, 32, 8'hB5, 8'h33);
    wr(sp_pkg::CTRL_OFS, 32'h80);
    rxf({2'b11, 8'h44, 1'b0}, 11, 32, 8'h80, 8'h33);
    // mode 1 from timer 1 auto-reload, 256-FE = 2 machine cycles
    wr(sp_pkg::PWR_OFS, 32'h00);
    // timer 1 interrupt stays off: the block has none to raise
    wr(sp_pkg::TIMER_MODE_OFS, 32'h21);
    wr(sp_pkg::T1_OFS, 32'hFEFE);
    wr(sp_pkg::CTRL_OFS, 32'h50);
    txf(8'hC3, 10, 768, {2'b11, 8'hC3, 1'b0});
    rdchk(sp_pkg::CTRL_OFS, 32'h52, "m1 tx done");
    wr(sp_pkg::CTRL_OFS, 32'h70);
    rxf({2'b10, 8'h99, 1'b0}, 10, 768, 8'h70, 8'h33);
    rxf({2'b11, 8'h99, 1'b0}, 10, 768, 8'h75, 8'h99);
    // mode 3: timer 2 sends, timer 1 receives
    wr(sp_pkg::RCAP_OFS, 32'hFFFE);
    wr(sp_pkg::T2_OFS, 32'hFFFE);
    wr(sp_pkg::T2CTL_OFS, 32'h14);
    rdchk(sp_pkg::RCAP_OFS, 32'hFFFE, "reload");
    wr(sp_pkg::CTRL_OFS, 32'hD8);
    txf(8'h0F, 11, 64, {2'b11, 8'h0F, 1'b0});
    rxf({2'b10, 8'h81, 1'b0}, 11, 768, 8'hDB, 8'h81);
    // slow-rate scheme: 16-bit timer 1, count reloaded by software
    wr(sp_pkg::TIMER_MODE_OFS, 32'h10);
    wr(sp_pkg::T1_OFS, 32'hFEEB);
    rdchk(sp_pkg::T1_OFS, 32'hFEEB, "t1 reload");
    // mode 0 with multiproc enable set, which must be ignored
    wr(sp_pkg::CTRL_OFS, 32'h20);
    wr(sp_pkg::BUF_OFS, 32'h96);
    far.shift(8'h00, b, per);
    check("m0 tx data", {24'h0, b}, 32'h96);
    check("m0 period", per, 12);
    repeat (24) @(posedge clk_i);
    rdchk(sp_pkg::CTRL_OFS, 32'h22, "m0 tx done");
    wr(sp_pkg::CTRL_OFS, 32'h30);
    far.shift(8'h6B, b, per);
    repeat (24) @(posedge clk_i);
    rdchk(sp_pkg::CTRL_OFS, 32'h31, "m0 rx done");
    rdchk(sp_pkg::BUF_OFS, 32'h6B, "m0 rx data");
    test_done();
  end
endmodule : tb_top
